// File: logic/bsm_defines.vh
`ifndef BSM_DEFINES_VH
`define BSM_DEFINES_VH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define BSM_ADDR_CTRL       12'h000
`define BSM_ADDR_ERR_STAT   12'h004
`define BSM_ADDR_ERR_ADDR   12'h008
`define BSM_ADDR_VID_CFG    12'h00C
`define BSM_ADDR_BASE0      12'h010
`define BSM_ADDR_BASE7      12'h02C

// ****************************************************************
// Field positions
// ****************************************************************
`define BSM_CTRL_WIDE_BIT   0
`define BSM_CTRL_REF_BIT    1
`define BSM_STAT_TAGA_BIT   0
`define BSM_STAT_TAGC_BIT   1
`define BSM_STAT_NXM_BIT    2
`define BSM_STAT_LOST_BIT   3
`define BSM_BASE_EN_BIT     31
`define BSM_BASE_SIZE_LSB   16
`define BSM_VID_EN_BIT      31

// ****************************************************************
// Acknowledge codes and sizes
// ****************************************************************
`define BSM_PACK_OK         3'h1
`define BSM_PACK_STC_FAIL   3'h2
`define BSM_PACK_HARD_ERR   3'h3
`define BSM_BACK_OK         2'h1
`define BSM_BACK_HARD_ERR   2'h3
`define BSM_NUM_DRAM_SETS   8
`define BSM_NUM_SETS        9
`define BSM_SIZE_MAX        3'h6
`define BSM_VID_SIZE_MAX    2'h2

`endif

// File: logic/bsm_memory_error.v
// Operation
// - Detect tag address, tag control, non-existent memory errors
// - Erroring transaction ends with hard-error acknowledge
// - Log address 33:5 and error kind
// - Logs frozen until software clears all three error-kind bits
// - Errors while frozen: hard error, set lost
// - Hard error overrides conditional-store failure
// - Lock flag undefined after load-locked error
// - DRAM drivers controlled by column strobe, write enable
// - One column strobe per longword, CBR refresh
// - Support 64-bit and 128-bit memory widths
// - Eight DRAM banksets plus one video bankset
// - Primary and secondary row strobe per bankset
// - Column strobe to longword mapping by width
// - Per-longword column strobes enable partial writes
// - DRAM bankset sizes 1M to 64M locations
// - Symmetric and asymmetric largest-DRAM addressing supported; this module drives no DRAM row/column address
// - Refresh all DRAM banksets together
// - Video bankset 128K to 512K locations
// - Split-strobe module used as two-bank bankset
// - Address compared against all banksets in parallel
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "bsm_defines.vh"

module bsm_memory_error (
    input  wire        hclk,               // System clock
    input  wire        hresetn,            // Async reset, active low
    input  wire        hsel,               // AHB slave select
    input  wire [31:0] haddr,              // AHB address
    input  wire [1:0]  htrans,             // AHB transfer type
    input  wire        hwrite,             // AHB write
    input  wire [2:0]  hsize,              // AHB size
    input  wire        hready,             // AHB bus ready
    input  wire [31:0] hwdata,             // AHB write data
    output wire [31:0] hrdata,             // AHB read data
    output wire        hreadyout,          // AHB slave ready
    output wire        hresp,              // AHB response
    input  wire        txn_valid,          // Transaction completes this cycle
    input  wire        txn_from_bridge,    // Requester is I/O bridge
    input  wire        txn_mem_space,      // Address in memory space
    input  wire        txn_write,          // Transaction writes memory
    input  wire        store_conditional,  // Conditional store transaction
    input  wire        load_locked,        // Load-locked transaction
    input  wire        lock_flag,          // Current lock flag state
    input  wire        tag_addr_par_err,   // Tag address parity error
    input  wire        tag_ctrl_par_err,   // Tag control parity error
    input  wire [33:5] system_bus_addr,    // Transaction address
    input  wire [3:0]  lw_mask,            // Longwords written
    input  wire        row_active,         // Row phase of access
    input  wire        col_active,         // Column phase of access
    input  wire        refresh_req,        // Refresh cycle request
    input  wire        vram_xfer,          // Video shift register load
    output reg  [2:0]  proc_cycle_ack,     // Processor acknowledge
    output reg  [1:0]  bridge_cycle_ack,   // Bridge acknowledge
    output reg         lock_flag_next,     // Lock flag after transaction
    output reg  [8:0]  row_strobe_primary_n,   // Row strobes, bank 0
    output reg  [8:0]  row_strobe_secondary_n, // Row strobes, bank 1
    output reg  [3:0]  col_strobe_n,       // Column strobes per longword
    output reg         mem_write_en_n,     // Memory write enable
    output reg         vram_transfer_oe_n, // Video transfer/output enable
    output reg         vram_special_func,  // Video special function
    output wire        lost_error_flag     // Lost error status
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg         wide_ff;
    reg  [3:0]  stat_ff;
    reg  [33:5] err_addr_ff;
    reg  [31:0] base_ff [0:7];
    reg  [31:0] vid_ff;
    reg         ahb_wr_ff;
    reg         ahb_rd_ff;
    reg  [11:0] ahb_addr_ff;
    reg  [31:0] rdata_ff;

    wire        logs_locked = |stat_ff[2:0];
    assign lost_error_flag = stat_ff[`BSM_STAT_LOST_BIT];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_ff;

    // ****************************************************************
    // Bankset decode
    // ****************************************************************
    // Compare width grows as the bankset shrinks; base bits below it ignored
    wire [8:0] set_hit;
    wire [8:0] set_sub;
    wire [4:0] shift_base = wide_ff ? 5'd24 : 5'd23;
    genvar g;
    generate
        for (g = 0; g < `BSM_NUM_SETS; g = g + 1) begin : g_set
            wire [31:0] cfg = (g == 8) ? vid_ff : base_ff[g % 8];
            wire [2:0]  sz  = cfg[`BSM_BASE_SIZE_LSB+2:`BSM_BASE_SIZE_LSB];
            wire [4:0]  sh  = (g == 8) ? (shift_base - 5'd3 + {3'b0, sz[1:0]})
                                       : (shift_base + {2'b0, sz});
            wire [33:0] pa  = {system_bus_addr, 5'h00};
            wire [33:0] ba  = {cfg[13:0], 20'h00000};
            assign set_hit[g] = cfg[31] && ((pa >> sh) == (ba >> sh));
            assign set_sub[g] = sh[0] ? pa[sh - 5'd1] : pa[sh - 5'd1];
        end
    endgenerate

    wire       nxm    = txn_mem_space && (set_hit == 9'h000);
    wire [2:0] kinds  = {nxm, tag_ctrl_par_err, tag_addr_par_err};
    wire       any_er = txn_valid && (|kinds);

    // ****************************************************************
    // Error logging and acknowledge
    // ****************************************************************
    wire clr_wr = ahb_wr_ff && (ahb_addr_ff == `BSM_ADDR_ERR_STAT);
    wire [3:0] clr_bits = clr_wr ? hwdata[3:0] : 4'h0;

    reg [3:0]  nxt_stat;
    reg [33:5] nxt_err_addr;

    // The first error of a burst is kept; later ones only raise the lost bit
    always @* begin
        nxt_stat     = stat_ff;
        nxt_err_addr = err_addr_ff;
        if (any_er && !logs_locked) begin
            nxt_stat[2:0] = kinds;
            nxt_err_addr  = system_bus_addr;
        end else begin
            nxt_stat[2:0] = stat_ff[2:0] & ~clr_bits[2:0];
        end
        // Set wins over a simultaneous clear, so no lost error goes unseen
        if (any_er && logs_locked)
            nxt_stat[3] = 1'b1;
        else
            nxt_stat[3] = stat_ff[3] & ~clr_bits[3];
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_ff     <= 4'h0;
            err_addr_ff <= 29'h0;
        end else begin
            stat_ff     <= nxt_stat;
            err_addr_ff <= nxt_err_addr;
        end
    end

    reg [2:0] nxt_proc_ack;
    reg [1:0] nxt_bridge_ack;
    reg       nxt_lock;

    // Errors are checked before the lock, so an erring conditional store
    // never reports a plain store failure
    always @* begin
        nxt_proc_ack   = 3'h0;
        nxt_bridge_ack = 2'h0;
        nxt_lock       = lock_flag;
        if (txn_valid) begin
            if (txn_from_bridge) begin
                if (any_er)
                    nxt_bridge_ack = `BSM_BACK_HARD_ERR;
                else
                    nxt_bridge_ack = `BSM_BACK_OK;
            end else if (any_er) begin
                nxt_proc_ack = `BSM_PACK_HARD_ERR;
            end else if (store_conditional && !lock_flag) begin
                nxt_proc_ack = `BSM_PACK_STC_FAIL;
            end else begin
                nxt_proc_ack = `BSM_PACK_OK;
            end
            // Lock left unchanged on error; its value is not defined
            if (load_locked && !any_er)
                nxt_lock = 1'b1;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            proc_cycle_ack   <= 3'h0;
            bridge_cycle_ack <= 2'h0;
            lock_flag_next   <= 1'b0;
        end else begin
            proc_cycle_ack   <= nxt_proc_ack;
            bridge_cycle_ack <= nxt_bridge_ack;
            lock_flag_next   <= nxt_lock;
        end
    end

    // ****************************************************************
    // Refresh sequencer
    // ****************************************************************
    // Columns fall one cycle ahead of the rows, so each bankset sees a
    // column-before-row cycle whatever the access inputs are doing
    localparam [3:0] RF_IDLE = 4'b0001;
    localparam [3:0] RF_COL  = 4'b0010;
    localparam [3:0] RF_ROW  = 4'b0100;
    localparam [3:0] RF_PRE  = 4'b1000;

    reg [3:0] rf_state_ff;
    reg [3:0] nxt_rf_state;

    always @* begin
        nxt_rf_state = rf_state_ff;
        case (rf_state_ff)
            RF_IDLE: begin
                if (refresh_req)
                    nxt_rf_state = RF_COL;
            end
            RF_COL: begin
                nxt_rf_state = RF_ROW;
            end
            RF_ROW: begin
                if (!refresh_req)
                    nxt_rf_state = RF_PRE;
            end
            RF_PRE: begin
                nxt_rf_state = RF_IDLE;
            end
            default: begin
                nxt_rf_state = RF_IDLE;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rf_state_ff <= RF_IDLE;
        end else begin
            rf_state_ff <= nxt_rf_state;
        end
    end

    wire rf_col  = (rf_state_ff == RF_COL) || (rf_state_ff == RF_ROW);
    wire rf_row  = (rf_state_ff == RF_ROW);
    wire rf_busy = (rf_state_ff != RF_IDLE);

    // ****************************************************************
    // Memory strobes
    // ****************************************************************
    reg [8:0] sel_ff;
    reg       sub_ff;
    reg [8:0] nxt_sel;
    reg       nxt_sub;
    reg [8:0] nxt_row_pri_n;
    reg [8:0] nxt_row_sec_n;
    reg [3:0] nxt_col_n;
    reg       nxt_we_n;
    reg       nxt_xfer_oe_n;
    reg       nxt_sfunc;

    always @* begin
        nxt_sel = sel_ff;
        nxt_sub = sub_ff;
        if (txn_valid && !any_er) begin
            nxt_sel = set_hit[8] ? 9'h100 : (set_hit & 9'h0FF);
            nxt_sub = |(set_hit & set_sub);
        end
        if (rf_busy) begin
            // All banksets refresh together; the last state precharges rows
            nxt_col_n     = rf_col ? (wide_ff ? 4'h0 : 4'hC) : 4'hF;
            nxt_row_pri_n = rf_row ? 9'h000 : 9'h1FF;
            nxt_row_sec_n = rf_row ? 9'h000 : 9'h1FF;
            nxt_we_n      = 1'b1;
        end else begin
            nxt_row_pri_n = ~(sel_ff & {9{row_active && !sub_ff}});
            nxt_row_sec_n = ~(sel_ff & {9{row_active && sub_ff}});
            // Narrow memory never uses strobes 3:2
            nxt_col_n = ~({4{col_active}} & (txn_write ? lw_mask : 4'hF)
                        & (wide_ff ? 4'hF : 4'h3));
            nxt_we_n  = ~(col_active && txn_write);
        end
        nxt_xfer_oe_n = ~(sel_ff[8] && (vram_xfer || (col_active && !txn_write)));
        nxt_sfunc     = sel_ff[8] && vram_xfer;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_ff                 <= 9'h000;
            sub_ff                 <= 1'b0;
            row_strobe_primary_n   <= 9'h1FF;
            row_strobe_secondary_n <= 9'h1FF;
            col_strobe_n           <= 4'hF;
            mem_write_en_n         <= 1'b1;
            vram_transfer_oe_n     <= 1'b1;
            vram_special_func      <= 1'b0;
        end else begin
            sel_ff                 <= nxt_sel;
            sub_ff                 <= nxt_sub;
            row_strobe_primary_n   <= nxt_row_pri_n;
            row_strobe_secondary_n <= nxt_row_sec_n;
            col_strobe_n           <= nxt_col_n;
            mem_write_en_n         <= nxt_we_n;
            vram_transfer_oe_n     <= nxt_xfer_oe_n;
            vram_special_func      <= nxt_sfunc;
        end
    end

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    integer i;
    wire take = hsel && hready && htrans[1];

    // Zero wait states: read data is latched at the address phase edge
    reg [31:0] nxt_rdata;
    always @* begin
        nxt_rdata = rdata_ff;
        if (take && !hwrite) begin
            case (haddr[11:0])
                `BSM_ADDR_CTRL:     nxt_rdata = {31'h0, wide_ff};
                `BSM_ADDR_ERR_STAT: nxt_rdata = {28'h0, stat_ff};
                `BSM_ADDR_ERR_ADDR: nxt_rdata = {3'h0, err_addr_ff};
                `BSM_ADDR_VID_CFG:  nxt_rdata = vid_ff;
                default: begin
                    if (haddr[11:0] >= `BSM_ADDR_BASE0 && haddr[11:0] <= `BSM_ADDR_BASE7)
                        nxt_rdata = base_ff[haddr[4:2] - 3'h4];
                    else
                        nxt_rdata = 32'h0;
                end
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ahb_wr_ff   <= 1'b0;
            ahb_rd_ff   <= 1'b0;
            ahb_addr_ff <= 12'h000;
            wide_ff     <= 1'b0;
            vid_ff      <= 32'h0;
            rdata_ff    <= 32'h0;
            for (i = 0; i < 8; i = i + 1)
                base_ff[i] <= 32'h0;
        end else begin
            ahb_wr_ff   <= take && hwrite;
            ahb_rd_ff   <= take && !hwrite;
            ahb_addr_ff <= haddr[11:0];
            rdata_ff    <= nxt_rdata;
            if (ahb_wr_ff) begin
                if (ahb_addr_ff == `BSM_ADDR_CTRL)
                    wide_ff <= hwdata[0];
                if (ahb_addr_ff == `BSM_ADDR_VID_CFG)
                    vid_ff <= {hwdata[31], 13'h0, hwdata[17:16], 2'h0, hwdata[13:0]};
                // Base holds PA<33:20>, size code 0..6 = 1M..64M locations
                if (ahb_addr_ff >= `BSM_ADDR_BASE0 && ahb_addr_ff <= `BSM_ADDR_BASE7)
                    base_ff[ahb_addr_ff[4:2] - 3'h4] <= {hwdata[31], 12'h0, hwdata[18:16],
                                                        2'h0, hwdata[13:0]};
            end
        end
    end

endmodule // bsm_memory_error
`default_nettype wire

// File: test/bsm_memory_error_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsm_defines.vh"
// ********
// Acknowledge and error log checks
// ********
module bsm_memory_error_props (
    input wire logic       hclk,              // Clock
    input wire logic       hresetn,           // Reset, active low
    input wire logic       hsel,              // Slave select
    input wire logic [1:0] htrans,            // Transfer type
    input wire logic       hwrite,            // Write
    input wire logic       hready,            // Bus ready
    input wire logic       hreadyout,         // Slave ready
    input wire logic       hresp,             // Response
    input wire logic       txn_valid,         // Transaction end
    input wire logic       txn_from_bridge,   // Bridge requester
    input wire logic       txn_mem_space,     // Memory space
    input wire logic       store_conditional, // Conditional store
    input wire logic       tag_addr_par_err,  // Tag address parity
    input wire logic       tag_ctrl_par_err,  // Tag control parity
    input wire logic [2:0] proc_cycle_ack,    // Processor ack
    input wire logic [1:0] bridge_cycle_ack,  // Bridge ack
    input wire logic       lost_error_flag    // Lost error
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire tag_err = tag_addr_par_err | tag_ctrl_par_err;
    property p_proc_hard;
        txn_valid && !txn_from_bridge && tag_err |=> proc_cycle_ack == `BSM_PACK_HARD_ERR;
    endproperty
    a_proc_hard: assert property (p_proc_hard) else $error("no hard ack");
    property p_bridge_hard;
        txn_valid && txn_from_bridge && tag_err |=>
            bridge_cycle_ack == `BSM_BACK_HARD_ERR && proc_cycle_ack == 3'h0;
    endproperty
    a_bridge_hard: assert property (p_bridge_hard) else $error("no bridge hard ack");
    property p_stc_hard;
        txn_valid && store_conditional && tag_err |=> proc_cycle_ack != `BSM_PACK_STC_FAIL;
    endproperty
    a_stc_hard: assert property (p_stc_hard) else $error("fail ack on error");
    property p_ok;
        txn_valid && !txn_from_bridge && !tag_err && !txn_mem_space && !store_conditional
            |=> proc_cycle_ack == `BSM_PACK_OK;
    endproperty
    a_ok: assert property (p_ok) else $error("clean ack wrong");
    property p_idle;
        !txn_valid |=> proc_cycle_ack == 3'h0 && bridge_cycle_ack == 2'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("stray ack");
    property p_lost_hold;
        lost_error_flag && !$past(hsel && hready && htrans[1] && hwrite) |=> lost_error_flag;
    endproperty
    a_lost_hold: assert property (p_lost_hold) else $error("lost flag dropped");
    property p_lost_rise;
        $rose(lost_error_flag) |-> $past(txn_valid && (tag_err || txn_mem_space));
    endproperty
    a_lost_rise: assert property (p_lost_rise) else $error("lost flag without error");
    property p_bus_okay;
        hreadyout && !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus stalled or erred");
    cover property (proc_cycle_ack == `BSM_PACK_HARD_ERR);
    cover property (bridge_cycle_ack == `BSM_BACK_HARD_ERR);
    cover property ($rose(lost_error_flag));
endmodule // bsm_memory_error_props
`default_nettype wire

// File: test/bsm_bank_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Memory banks seen from the strobes
// ********
module bsm_bank_model (
    input wire logic       hclk,                   // Clock
    input wire logic [8:0] row_strobe_primary_n,   // Bank 0 rows
    input wire logic [8:0] row_strobe_secondary_n, // Bank 1 rows
    input wire logic [3:0] col_strobe_n,           // Longword columns
    output logic     [7:0] cbr_count               // Refreshes seen
);
    localparam int VID_ROWS = 512;
    logic [17:0] row_q;
    logic [3:0]  col_q;
    initial cbr_count = 8'h00;
    // Column low before a row strobe falls is a refresh, not an access
    always @(posedge hclk) begin
        row_q <= {row_strobe_secondary_n, row_strobe_primary_n};
        col_q <= col_strobe_n;
        if (|(row_q & ~{row_strobe_secondary_n, row_strobe_primary_n}) && ~&col_q)
            cbr_count <= cbr_count + 8'h01;
    end
endmodule // bsm_bank_model
`default_nettype wire

// File: test/test_bankset_memory_and_error_log.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsm_defines.vh"
// ********
// Error log and strobe bench
// ********
module test_bankset_memory_and_error_log;
    logic hclk, hresetn, hsel, hwrite, txn_valid, txn_from_bridge, txn_mem_space, txn_write;
    logic store_conditional, load_locked, lock_flag, tag_addr_par_err, tag_ctrl_par_err;
    logic row_active, col_active, refresh_req, vram_xfer;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [33:5] system_bus_addr;
    logic [3:0] lw_mask;
    wire [31:0] hrdata;
    wire hreadyout, hresp, lock_flag_next, vram_transfer_oe_n, vram_special_func;
    wire lost_error_flag, mem_write_en_n;
    wire [2:0] proc_cycle_ack;
    wire [1:0] bridge_cycle_ack;
    wire [8:0] row_strobe_primary_n, row_strobe_secondary_n;
    wire [3:0] col_strobe_n;
    wire [7:0] cbr_count;
    int failures, comparisons;
    bsm_memory_error dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .txn_valid,
        .txn_from_bridge, .txn_mem_space, .txn_write, .store_conditional, .load_locked,
        .lock_flag, .tag_addr_par_err, .tag_ctrl_par_err, .system_bus_addr, .lw_mask,
        .row_active, .col_active, .refresh_req, .vram_xfer, .proc_cycle_ack,
        .bridge_cycle_ack, .lock_flag_next, .row_strobe_primary_n, .row_strobe_secondary_n,
        .col_strobe_n, .mem_write_en_n, .vram_transfer_oe_n, .vram_special_func,
        .lost_error_flag);
    bsm_bank_model u_banks (.hclk, .row_strobe_primary_n, .row_strobe_secondary_n,
        .col_strobe_n, .cbr_count);
    initial begin
        hclk = 0;
        forever #2 hclk = ~hclk;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= {20'h0, a}; hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        cmp(rd, exp);
    endtask
    // Acks stand one cycle only, so they are looked at in that cycle
    task automatic txn(input logic br, mem, stc, ta, tc, input logic [33:5] pa,
                       input logic [2:0] exp);
        @(posedge hclk);
        txn_valid <= 1'b1; txn_from_bridge <= br; txn_mem_space <= mem;
        store_conditional <= stc; load_locked <= ta; txn_write <= stc;
        tag_addr_par_err <= ta; tag_ctrl_par_err <= tc; system_bus_addr <= pa;
        @(posedge hclk);
        txn_valid <= 1'b0; tag_addr_par_err <= 1'b0; tag_ctrl_par_err <= 1'b0;
        #1;
        cmp({29'h0, br ? {1'b0, bridge_cycle_ack} : proc_cycle_ack}, {29'h0, exp});
    endtask
    task automatic final_report;
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #40000;
        failures++;
        final_report;
    end
    initial begin
        {hsel, hwrite, txn_valid, txn_from_bridge, txn_mem_space, txn_write} = 6'h00;
        {store_conditional, load_locked, lock_flag, tag_addr_par_err, tag_ctrl_par_err} = 5'h00;
        {row_active, col_active, refresh_req, vram_xfer} = 4'h0;
        {haddr, hwdata, htrans, system_bus_addr, lw_mask} = 0;
        hsize = 3'h2;
        hresetn = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        cmp({14'h0, row_strobe_secondary_n, row_strobe_primary_n}, 32'h3FFFF);
        rd_chk(`BSM_ADDR_ERR_STAT, 32'h0);
        txn(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 29'h0ABCDE12, 3'h3);
        rd_chk(`BSM_ADDR_ERR_STAT, 32'h1);
        rd_chk(`BSM_ADDR_ERR_ADDR, 32'h0ABCDE12);
        txn(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 29'h1555AAAA, 3'h3);
        rd_chk(`BSM_ADDR_ERR_STAT, 32'h9);
        rd_chk(`BSM_ADDR_ERR_ADDR, 32'h0ABCDE12);
        ahb(1'b1, `BSM_ADDR_ERR_STAT, 32'hF);
        rd_chk(`BSM_ADDR_ERR_STAT, 32'h0);
        txn(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 29'h00000100, 3'h3);
        rd_chk(`BSM_ADDR_ERR_STAT, 32'h4);
        ahb(1'b1, `BSM_ADDR_ERR_STAT, 32'hF);
        ahb(1'b1, `BSM_ADDR_BASE0, 32'h80000000);
        ahb(1'b1, `BSM_ADDR_BASE7, 32'h80000010);
        txn(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 29'h00000100, 3'h1);
        txn(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 29'h000BFFFF, 3'h1);
        txn(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 29'h000C0000, 3'h3);
        txn(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 29'h00000100, 3'h2);
        lock_flag <= 1'b1;
        txn(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 29'h00000100, 3'h1);
        txn(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 29'h00000100, 3'h3);
        cmp({31'h0, lost_error_flag}, 32'h1);
        rd_chk(12'h100, 32'h0);
        lock_flag <= 1'b0;
        @(posedge hclk);
        txn_valid <= 1'b1; load_locked <= 1'b1; store_conditional <= 1'b0;
        @(posedge hclk);
        txn_valid <= 1'b0; load_locked <= 1'b0;
        #1;
        cmp({31'h0, lock_flag_next}, 32'h1);
        @(posedge hclk);
        row_active <= 1'b1; col_active <= 1'b1; txn_write <= 1'b1; lw_mask <= 4'hF;
        repeat (3) @(posedge hclk);
        #1;
        cmp({30'h0, col_strobe_n[3:2]}, 32'h3);
        cmp({13'h0, row_strobe_secondary_n, row_strobe_primary_n, mem_write_en_n}, 32'h7FFFC);
        cmp({30'h0, vram_transfer_oe_n, vram_special_func}, 32'h2);
        row_active <= 1'b0; col_active <= 1'b0; txn_write <= 1'b0; lw_mask <= 4'h0;
        refresh_req <= 1'b1;
        repeat (8) @(posedge hclk);
        refresh_req <= 1'b0;
        repeat (8) @(posedge hclk);
        cmp({31'h0, cbr_count != 8'h00}, 32'h1);
        final_report;
    end
endmodule // test_bankset_memory_and_error_log
bind bsm_memory_error bsm_memory_error_props u_props (.hclk, .hresetn, .hsel, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .txn_valid, .txn_from_bridge, .txn_mem_space,
    .store_conditional, .tag_addr_par_err, .tag_ctrl_par_err, .proc_cycle_ack,
    .bridge_cycle_ack, .lost_error_flag);
`default_nettype wire
